// File: hw/acp_config_port.sv
// configuration control port: serial register writes and strap decoding
`timescale 1ns/10ps
`default_nettype none
module acp_config_port
	import acp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       serClk,
	input  wire logic       serialSelectN,
	input  wire logic       serialShiftIn,
	input  wire logic       hwResetPin,
	input  wire logic       powerDownPin,
	input  wire logic [1:0] senLevel,
	input  wire logic       sclkLevel,
	input  wire logic       sdataLevel,
	input  wire logic [1:0] strapInterfaceSelect,
	input  wire logic [1:0] strapSerializeEdgeSelect,
	input  wire logic [1:0] strapOrderFormatSelect,
	output acp_cfg_t        cfgOut,
	output logic            pinCtrlMode
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int PinW = 12;               // width of the pin bundle
	localparam int WrDelay = `ACP_WR_DELAY_CYC;  // commit delay for checks, cycles

	wire  [PinW-1:0] pinRaw;                // asynchronous pins, packed
	logic [PinW-1:0] pinS1_r;               // first stage, read by second only
	logic [PinW-1:0] pinS2_r;               // settled pin levels

	assign pinRaw = {hwResetPin, powerDownPin, senLevel, sclkLevel, sdataLevel,
		strapInterfaceSelect, strapSerializeEdgeSelect, strapOrderFormatSelect};

	// straps and level pins pass two flops before anything looks at them
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pinS1_r <= '0;
			pinS2_r <= '0;
		end else begin
			pinS1_r <= pinRaw;
			pinS2_r <= pinS1_r;
		end
	end

	// named views of the settled pins
	wire       rstPinS  = pinS2_r[11];     // hardware reset pin level
	wire       pdnPinS  = pinS2_r[10];     // dedicated power-down pin
	wire [1:0] senLvlS  = pinS2_r[9:8];    // four-level select pin
	wire       sclkLvlS = pinS2_r[7];      // clock line used as a level
	wire       sdatLvlS = pinS2_r[6];      // data line used as a level
	wire [1:0] ifSelS   = pinS2_r[5:4];    // interface strap
	wire [1:0] serSelS  = pinS2_r[3:2];    // serialize and edge strap
	wire [1:0] ordSelS  = pinS2_r[1:0];    // order and format strap

	// ----------------------------------------------------------------
	// serial link domain
	// ----------------------------------------------------------------
	acp_word_t linkWord;                    // last full word, stable between toggles
	logic      linkTgl;                     // flips once per full word

	acp_serial_shift uShift (
		.serClk        (serClk),
		.linkRst       (sys_rst),
		.serialSelectN (serialSelectN),
		.serialShiftIn (serialShiftIn),
		.wordOut       (linkWord),
		.wordTgl       (linkTgl)
	);

	// ----------------------------------------------------------------
	// word handover into the system clock
	// ----------------------------------------------------------------
	logic tglS1_r;                          // first stage, read by second only
	logic tglS2_r;                          // settled toggle
	logic tglS3_r;                          // previous settled toggle
	wire  wordEvt;                          // one pulse per arriving word

	assign wordEvt = tglS2_r ^ tglS3_r;

	// toggle crossing; the word itself is held still for 16 serial clocks
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tglS1_r <= 1'b0;
			tglS2_r <= 1'b0;
			tglS3_r <= 1'b0;
		end else begin
			tglS1_r <= linkTgl;
			tglS2_r <= tglS1_r;
			tglS3_r <= tglS2_r;
		end
	end

	// ----------------------------------------------------------------
	// commit sequencer
	// ----------------------------------------------------------------
	acp_state_t state_r;                    // idle or waiting to commit
	acp_state_t stateNxt;
	logic [4:0] waitCnt_r;                  // cycles left before commit
	logic [4:0] waitCntNxt;
	acp_word_t  pend_r;                     // word waiting to commit
	wire        commit;                     // pulse that writes the register file

	assign commit = (state_r == ACP_WAIT) && (waitCnt_r == 5'h00);

	// the delay mimics the converter's settling of a write, so software
	// timing written against the real part keeps working
	// delayed commit
	always_comb begin
		stateNxt   = state_r;
		waitCntNxt = waitCnt_r;
		case (state_r)
			ACP_IDLE: begin
				// wait for a word
				if (wordEvt) begin
					stateNxt   = ACP_WAIT;
					waitCntNxt = 5'(`ACP_WR_DELAY_CYC - 4);
				end
			end
			ACP_WAIT: begin
				// count down, then commit
				if (waitCnt_r == 5'h00) begin
					stateNxt = ACP_IDLE;
				end else begin
					waitCntNxt = waitCnt_r - 5'h01;
				end
			end
			default: begin
				stateNxt   = ACP_IDLE;
				waitCntNxt = 5'h00;
			end
		endcase
	end

	// sequencer flops; word captured when the crossing pulse arrives
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r   <= ACP_IDLE;
			waitCnt_r <= 5'h00;
			pend_r    <= '0;
		end else begin
			state_r   <= stateNxt;
			waitCnt_r <= waitCntNxt;
			if (wordEvt) begin
				pend_r <= linkWord;
			end
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [`ACP_DATA_BITS-1:0] regFile_r [0:`ACP_REG_COUNT-1];   // write-only registers
	wire                       swReset;    // reset bit written to register zero
	wire                       clearAll;   // any reset source

	assign swReset  = commit && (pend_r.addr == `ACP_ADDR_PWR) && pend_r.data[`ACP_BIT_SWRST];
	// pin held high also keeps registers cleared, which is the pin-only mode
	assign clearAll = sys_rst || rstPinS || swReset;

	// reset bit is never stored, so it reads back as cleared at once
	// clear all bits
	always_ff @(posedge clk_sys) begin
		if (clearAll) begin
			for (int i = 0; i < `ACP_REG_COUNT; i++) begin
				regFile_r[i] <= `ACP_REG_RESET;
			end
		end else if (commit) begin
			regFile_r[pend_r.addr] <= pend_r.data;
		end
	end

	// one bit of a register
	function automatic logic regBit(input logic [`ACP_DATA_BITS-1:0] r, input int b);
		regBit = r[b];
	endfunction : regBit

	// ----------------------------------------------------------------
	// register fields
	// ----------------------------------------------------------------
	wire [`ACP_DATA_BITS-1:0] regPwr  = regFile_r[`ACP_ADDR_PWR];   // power, reference
	wire [`ACP_DATA_BITS-1:0] regPat  = regFile_r[`ACP_ADDR_PAT];   // patterns, format
	wire [`ACP_DATA_BITS-1:0] regMode = regFile_r[`ACP_ADDR_MODE];  // override, modes
	wire                      ovrd    = regBit(regMode, `ACP_BIT_OVRD);

	// pin-only mode is chosen by holding the reset pin high
	wire pinMode = rstPinS;

	// ----------------------------------------------------------------
	// select line and clock/data line functions
	// ----------------------------------------------------------------
	wire senRefInt;                          // reference choice from select level
	wire senGain;                            // coarse gain from select level
	wire [2:0] pinPat;                       // pattern from the line pair
	wire pairPdn;                            // power down from the line pair

	assign senRefInt = (senLvlS == `ACP_LVL_5OF6) || (senLvlS == `ACP_LVL_VDD);
	assign senGain   = (senLvlS == `ACP_LVL_3OF6) || (senLvlS == `ACP_LVL_5OF6);

	assign pinPat  = (!sclkLvlS && sdatLvlS) ? `ACP_PAT_SYNC :
		(sclkLvlS && sdatLvlS) ? `ACP_PAT_DESKEW : `ACP_PAT_NORMAL;
	assign pairPdn = sclkLvlS && !sdatLvlS;

	// ----------------------------------------------------------------
	// strap decode
	// ----------------------------------------------------------------
	// the unused level is taken as the ground setting
	// interface, serialize and edge, order and format straps
	wire strWire2 = ifSelS[1];
	wire strSdr   = (ifSelS == `ACP_LVL_5OF6);
	wire strSer16 = (serSelS == `ACP_LVL_3OF6) || (serSelS == `ACP_LVL_5OF6);
	wire strRise  = serSelS[1];
	wire strLsb   = ordSelS[1];
	wire strOffB  = (ordSelS == `ACP_LVL_3OF6) || (ordSelS == `ACP_LVL_5OF6);

	// ----------------------------------------------------------------
	// priority between pins and registers
	// ----------------------------------------------------------------
	acp_cfg_t cfgNxt;                        // resolved configuration

	always_comb begin
		cfgNxt = '0;
		cfgNxt.globalPowerDown = pdnPinS ||
			(pinMode ? pairPdn : regBit(regPwr, `ACP_BIT_GPDN));
		cfgNxt.chanPowerDown = regPwr[`ACP_BIT_CHPD_MSB:`ACP_BIT_CHPD_LSB];
		if (pinMode) begin
			// lines act as levels
			cfgNxt.patternSel  = pinPat;
			cfgNxt.refInternal = senRefInt;
			cfgNxt.coarseGain  = senGain;
		end else begin
			cfgNxt.patternSel  = regPat[`ACP_BIT_PAT_MSB:`ACP_BIT_PAT_LSB];
			cfgNxt.refInternal = regBit(regPwr, `ACP_BIT_REF);
			cfgNxt.coarseGain  = ovrd && regBit(regMode, `ACP_BIT_CGAIN);
		end
		// straps apply from power-up until software takes over
		// override selects source
		if (ovrd) begin
			cfgNxt.twoWire      = regBit(regMode, `ACP_BIT_WIRE2);
			cfgNxt.sdrClock     = regBit(regMode, `ACP_BIT_SDR);
			cfgNxt.serialize16  = regBit(regMode, `ACP_BIT_SER16);
			cfgNxt.lsbFirst     = regBit(regMode, `ACP_BIT_LSBF);
			cfgNxt.offsetBinary = regBit(regPat, `ACP_BIT_FMT);
			cfgNxt.captureRising = regBit(regMode, `ACP_BIT_EDGE);
		end else begin
			cfgNxt.twoWire      = strWire2;
			cfgNxt.sdrClock     = strSdr;
			cfgNxt.serialize16  = strSer16;
			cfgNxt.lsbFirst     = strLsb;
			cfgNxt.offsetBinary = strOffB;
			cfgNxt.captureRising = strRise;
		end
		// edge only in two-wire single rate
		cfgNxt.captureRising = cfgNxt.captureRising && cfgNxt.twoWire && cfgNxt.sdrClock;
	end

	// outputs come from flops
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cfgOut      <= '0;
			pinCtrlMode <= 1'b0;
		end else begin
			cfgOut      <= cfgNxt;
			pinCtrlMode <= pinMode;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// pin forces power down
	pdn_pin_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		pdnPinS |=> cfgOut.globalPowerDown)
		else $error("power-down pin did not force global power down");

	gain_block_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!pinMode && !ovrd) |=> !cfgOut.coarseGain)
		else $error("coarse gain set without override");

	commit_delay_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		commit |-> $past(wordEvt, WrDelay - 3))
		else $error("register commit not at the fixed delay");

	sw_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		swReset |=> (regPwr == '0) && (regMode == '0))
		else $error("software reset left registers set");

	// reset pin clears override
	// gain may still come from the select level while the pin keeps pin mode
	hw_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rstPinS |=> !ovrd ##1 cfgOut.coarseGain == ($past(pinMode) && $past(senGain)))
		else $error("hardware reset left override set");

	sen_ground_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pinMode && senLvlS == `ACP_LVL_GND) |=> !cfgOut.refInternal && !cfgOut.coarseGain)
		else $error("ground select level decoded wrongly");

	ovrd_wire_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ovrd |=> cfgOut.twoWire == $past(regMode[`ACP_BIT_WIRE2]))
		else $error("override did not take wire count from register");

	pair_sync_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pinMode && !sclkLvlS && sdatLvlS) |=> cfgOut.patternSel == `ACP_PAT_SYNC)
		else $error("line pair did not select sync pattern");
endmodule : acp_config_port
`default_nettype wire

// File: hw/acp_map.svh
// constants for the configuration control port: register map, fields, levels, timing
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH
// ----------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------
`define ACP_WORD_BITS      16
`define ACP_ADDR_BITS      5
`define ACP_DATA_BITS      11
`define ACP_CNT_BITS       4
`define ACP_LAST_BIT       4'hf
`define ACP_REG_COUNT      32
`define ACP_REG_RESET      11'h000
// ----------------------------------------------------------------
// register addresses and field positions
// ----------------------------------------------------------------
`define ACP_ADDR_PWR       5'h00
`define ACP_ADDR_PAT       5'h0a
`define ACP_ADDR_MODE      5'h0d
`define ACP_BIT_SWRST      10
`define ACP_BIT_REF        5
`define ACP_BIT_GPDN       0
`define ACP_BIT_CHPD_LSB   1
`define ACP_BIT_CHPD_MSB   4
`define ACP_BIT_FMT        9
`define ACP_BIT_PAT_LSB    5
`define ACP_BIT_PAT_MSB    7
`define ACP_BIT_OVRD       10
`define ACP_BIT_LSBF       6
`define ACP_BIT_CGAIN      5
`define ACP_BIT_EDGE       4
`define ACP_BIT_SER16      2
`define ACP_BIT_SDR        1
`define ACP_BIT_WIRE2      0
// ----------------------------------------------------------------
// pattern codes, strap level codes
// ----------------------------------------------------------------
`define ACP_PAT_NORMAL     3'h0
`define ACP_PAT_SYNC       3'h1
`define ACP_PAT_DESKEW     3'h2
`define ACP_LVL_GND        2'h0
`define ACP_LVL_3OF6       2'h1
`define ACP_LVL_5OF6       2'h2
`define ACP_LVL_VDD        2'h3
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ACP_CLK_PERIOD_NS  4
`define ACP_WR_DELAY_NS    100
`define ACP_WR_DELAY_CYC   (`ACP_WR_DELAY_NS / `ACP_CLK_PERIOD_NS)
`endif

// File: hw/acp_pkg.sv
// types shared by the configuration control port
`default_nettype none
`include "acp_map.svh"
package acp_pkg;
	// one serial word, address first
	typedef struct packed {
		logic [`ACP_ADDR_BITS-1:0] addr;
		logic [`ACP_DATA_BITS-1:0] data;
	} acp_word_t;
	// resolved configuration driven to the converter
	typedef struct packed {
		logic       globalPowerDown;
		logic [3:0] chanPowerDown;
		logic [2:0] patternSel;
		logic       refInternal;
		logic       coarseGain;
		logic       twoWire;
		logic       sdrClock;
		logic       serialize16;
		logic       captureRising;
		logic       lsbFirst;
		logic       offsetBinary;
	} acp_cfg_t;
	// commit sequencer
	typedef enum logic [0:0] {
		ACP_IDLE = 1'b0,
		ACP_WAIT = 1'b1
	} acp_state_t;
endpackage : acp_pkg
`default_nettype wire

// File: hw/acp_serial_shift.sv
// serial shifter on the falling edge of the serial clock
`timescale 1ns/10ps
`default_nettype none
module acp_serial_shift
	import acp_pkg::*;
(
	input  wire logic      serClk,
	input  wire logic      linkRst,
	input  wire logic      serialSelectN,
	input  wire logic      serialShiftIn,
	output acp_word_t      wordOut,
	output logic           wordTgl
);
	// ----------------------------------------------------------------
	// shifting
	// ----------------------------------------------------------------
	logic [`ACP_CNT_BITS-1:0]  bitCnt_r;   // bits taken in current word
	logic [`ACP_WORD_BITS-1:0] shift_r;    // msb-first shift register
	wire  [`ACP_WORD_BITS-1:0] shiftNxt;   // shift with new bit
	wire                       wordDone;   // sixteenth falling edge

	assign shiftNxt = {shift_r[`ACP_WORD_BITS-2:0], serialShiftIn};
	assign wordDone = (bitCnt_r == `ACP_LAST_BIT);

	// count clears while select is high, so a partial word is simply forgotten
	// partial word dropped
	always_ff @(negedge serClk or posedge serialSelectN) begin
		if (serialSelectN) begin
			bitCnt_r <= '0;
		end else begin
			bitCnt_r <= bitCnt_r + 4'h1;
		end
	end

	always_ff @(negedge serClk) begin
		shift_r <= shiftNxt;
	end

	// word and toggle only move once per full word; held stable for the other side
	// commit each word
	always_ff @(negedge serClk or posedge linkRst) begin
		if (linkRst) begin
			wordOut <= '0;
			wordTgl <= 1'b0;
		end else if (!serialSelectN && wordDone) begin
			wordOut <= acp_word_t'(shiftNxt);
			wordTgl <= ~wordTgl;
		end
	end

	word_toggle_a: assert property (
		@(negedge serClk) disable iff (serialSelectN || linkRst)
		wordDone |=> wordTgl != $past(wordTgl))
		else $error("word toggle missing after sixteenth bit");
	partial_hold_a: assert property (
		@(negedge serClk) disable iff (serialSelectN || linkRst)
		!wordDone |=> $stable(wordTgl))
		else $error("word toggle moved before word complete");
endmodule : acp_serial_shift
`default_nettype wire

// File: verif/acp_host_model.sv
// host model that drives the serial write lines of the configuration port
`timescale 1ns/10ps
`default_nettype none
module acp_host_model (
	output var logic serClk,
	output var logic serialSelectN,
	output var logic serialShiftIn
);
	// idle: select high, clock parked low
	initial begin
		serClk        = 1'b0;
		serialSelectN = 1'b1;
		serialShiftIn = 1'b0;
	end
	// ----------------------------------------------------------------
	// one select-low frame; the clock runs only inside it
	// ----------------------------------------------------------------
	task automatic sendFrame(input logic [47:0] bits, input int nBits);
		serialSelectN = 1'b0;
		#25;
		for (int i = nBits - 1; i >= 0; i--) begin
			serClk = 1'b1;
			serialShiftIn = bits[i];
			#7.5;
			serClk = 1'b0;
			#7.5;
		end
		// hold select past the last falling edge
		#17.5;
		serialSelectN = 1'b1;
		// a released line shows no stale value
		serialShiftIn = ~serialShiftIn;
	endtask : sendFrame
endmodule : acp_host_model
`default_nettype wire

// File: verif/acp_config_port_bench.sv
// self-checking bench for the configuration control port
`timescale 1ns/10ps
`default_nettype none
`include "acp_map.svh"
module acp_config_port_bench
	import acp_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic       clk_sys;
	logic       sys_rst;
	logic       hwResetPin;
	logic       powerDownPin;
	logic       sclkLevel;
	logic       sdataLevel;
	logic [1:0] senLevel;
	logic [1:0] strapI;
	logic [1:0] strapS;
	logic [1:0] strapO;
	wire logic  serClk;
	wire logic  serialSelectN;
	wire logic  serialShiftIn;
	acp_cfg_t   cfgOut;
	logic       pinCtrlMode;
	int         errors;
	int         check_count;
	logic [10:0] r0;    // shadow of power register
	logic [10:0] rA;    // shadow of pattern register
	logic [10:0] rD;    // shadow of mode register

	always #2 clk_sys = ~clk_sys;

	acp_config_port DUT (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .serClk(serClk),
		.serialSelectN(serialSelectN), .serialShiftIn(serialShiftIn),
		.hwResetPin(hwResetPin), .powerDownPin(powerDownPin), .senLevel(senLevel),
		.sclkLevel(sclkLevel), .sdataLevel(sdataLevel), .strapInterfaceSelect(strapI),
		.strapSerializeEdgeSelect(strapS), .strapOrderFormatSelect(strapO),
		.cfgOut(cfgOut), .pinCtrlMode(pinCtrlMode)
	);
	acp_host_model host (
		.serClk(serClk), .serialSelectN(serialSelectN), .serialShiftIn(serialShiftIn)
	);

	// ----------------------------------------------------------------
	// expected configuration from pins and shadow registers
	// ----------------------------------------------------------------
	function automatic acp_cfg_t expCfg();
		acp_cfg_t c;
		c = '0;
		c.chanPowerDown = r0[4:1];
		if (hwResetPin) begin
			c.globalPowerDown = sclkLevel & ~sdataLevel;
			c.patternSel = {1'b0, sclkLevel & sdataLevel, ~sclkLevel & sdataLevel};
			c.refInternal = senLevel[1];
			c.coarseGain = senLevel[1] ^ senLevel[0];
		end else begin
			c.globalPowerDown = r0[0];
			c.patternSel = rA[7:5];
			c.refInternal = r0[5];
			c.coarseGain = rD[10] & rD[5];
		end
		c.globalPowerDown = c.globalPowerDown | powerDownPin;
		if (rD[10]) begin
			c.twoWire = rD[0];
			c.sdrClock = rD[1];
			c.serialize16 = rD[2];
			c.captureRising = rD[4];
			c.lsbFirst = rD[6];
			c.offsetBinary = rA[9];
		end else begin
			c.twoWire = strapI[1];
			c.sdrClock = (strapI == 2'h2);
			c.serialize16 = strapS[1] ^ strapS[0];
			c.captureRising = strapS[1];
			c.lsbFirst = strapO[1];
			c.offsetBinary = strapO[1] ^ strapO[0];
		end
		// capture edge only matters in two-wire single rate
		c.captureRising = c.captureRising & c.twoWire & c.sdrClock;
		return c;
	endfunction : expCfg

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic shadow(input logic [4:0] a, input logic [10:0] d);
		if (a == `ACP_ADDR_PWR && d[10]) begin
			r0 = '0;
			rA = '0;
			rD = '0;
		end else if (a == `ACP_ADDR_PWR) begin
			r0 = d;
		end else if (a == `ACP_ADDR_PAT) begin
			rA = d;
		end else if (a == `ACP_ADDR_MODE) begin
			rD = d;
		end
	endtask : shadow

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : settle

	// one word write; checks it is not applied early and is applied later
	task automatic wr(input logic [4:0] a, input logic [10:0] d);
		host.sendFrame({32'h0, a, d}, 16);
		settle(15);
		// old register contents must still show some 80 ns after the last bit
		chk("early", cfgOut, expCfg());
		shadow(a, d);
		settle(25);
		chk("cfg", cfgOut, expCfg());
	endtask : wr

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_pins();
		@(posedge clk_sys);
		hwResetPin <= 1'b1;
		r0 = '0;
		rA = '0;
		rD = '0;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			{sclkLevel, sdataLevel} <= 2'(k);
			senLevel <= 2'(k);
			strapI <= 2'(k);
			strapS <= 2'(k) ^ 2'h1;
			strapO <= 2'(k);
			settle(8);
			chk("pins", cfgOut, expCfg());
			chk("pinmode", {15'h0, pinCtrlMode}, 16'h0001);
		end
		// a write while the reset pin is high is lost
		host.sendFrame({32'h0, `ACP_ADDR_PWR, 11'h03f}, 16);
		settle(40);
		chk("lost", cfgOut, expCfg());
		@(posedge clk_sys);
		hwResetPin <= 1'b0;
		{sclkLevel, sdataLevel} <= 2'h0;
		settle(8);
	endtask : t_pins

	task automatic t_override();
		wr(`ACP_ADDR_MODE, 11'h477);
		wr(`ACP_ADDR_PAT, 11'h200);
		wr(`ACP_ADDR_MODE, 11'h020);
	endtask : t_override

	task automatic t_multi();
		host.sendFrame({11'h0, `ACP_ADDR_PWR, 11'h03e, `ACP_ADDR_PAT, 11'h020, 5'h1f}, 37);
		shadow(`ACP_ADDR_PWR, 11'h03e);
		shadow(`ACP_ADDR_PAT, 11'h020);
		settle(40);
		chk("multi", cfgOut, expCfg());
		for (int p = 2; p >= 0; p--) begin
			wr(`ACP_ADDR_PAT, {3'h0, 3'(p), 5'h00});
		end
	endtask : t_multi

	task automatic t_pdn();
		wr(`ACP_ADDR_PWR, 11'h001);
		@(posedge clk_sys);
		powerDownPin <= 1'b1;
		wr(`ACP_ADDR_PWR, 11'h000);
		@(posedge clk_sys);
		powerDownPin <= 1'b0;
		settle(8);
		chk("pdnoff", cfgOut, expCfg());
	endtask : t_pdn

	task automatic t_reset();
		wr(`ACP_ADDR_MODE, 11'h417);
		wr(`ACP_ADDR_PWR, 11'h400);
		wr(`ACP_ADDR_PWR, 11'h020);
		wr(`ACP_ADDR_MODE, 11'h403);
		@(posedge clk_sys);
		hwResetPin <= 1'b1;
		settle(3);
		hwResetPin <= 1'b0;
		r0 = '0;
		rA = '0;
		rD = '0;
		settle(8);
		chk("hwreset", cfgOut, expCfg());
		chk("pinmodeoff", {15'h0, pinCtrlMode}, 16'h0000);
	endtask : t_reset

	task automatic end_sim();
		if (errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		sys_rst = 1'b1;
		hwResetPin = 1'b0;
		powerDownPin = 1'b0;
		sclkLevel = 1'b0;
		sdataLevel = 1'b0;
		senLevel = 2'h0;
		strapI = 2'h3;
		strapS = 2'h2;
		strapO = 2'h2;
		errors = 0;
		check_count = 0;
		r0 = '0;
		rA = '0;
		rD = '0;
		// supply wait shrunk to reset hold
		settle(2);
		sys_rst <= 1'b0;
		settle(6);
		chk("powerup", cfgOut, expCfg());
		t_pins();
		t_override();
		t_multi();
		t_pdn();
		t_reset();
		end_sim();
	end

	initial begin
		#100000;
		errors++;
		end_sim();
	end
endmodule : acp_config_port_bench
`default_nettype wire
